/* File: rtl/bsw_pkg.sv */
package bsw_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_ADDR  = 16'hFF7C;
  localparam logic [15:0] HUND_ADDR  = 16'hFF7D;
  localparam logic [15:0] TENTH_ADDR = 16'hFF7E;
  localparam logic [15:0] IEN_ADDR   = 16'hFFE7;
  localparam logic [15:0] PEND_ADDR  = 16'hFFF7;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int RUN_BIT    = 0;
  localparam int CLEAR_BIT  = 1;
  localparam int TENTH_BIT  = 0;
  localparam int SECOND_BIT = 1;

  localparam logic [3:0] DIGIT_RST = 4'h0;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [1:0] FLAGS_RST = 2'h0;
  localparam logic [3:0] RDATA_RST = 4'h0;

  // ----------------------------------------------------------------
  // Timing counts in ticks of the 256 Hz source
  // ----------------------------------------------------------------
  localparam logic [1:0] SHORT_STEP = 2'h2;
  localparam logic [1:0] LONG_STEP  = 2'h3;
  localparam logic [1:0] PRE_RST    = 2'h0;

  // ----------------------------------------------------------------
  // Register port request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [3:0]  wdata;
    logic        wr;
    logic        rd;
  } bsw_req_s;

endpackage

/* File: rtl/bsw_stopwatch.sv */
`timescale 1ns/10ps
`default_nettype none

module bsw_stopwatch (
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        tick_256hz_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [3:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [3:0]  rdata_o,
  output logic             irq_tenth_o,
  output logic             irq_second_o
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // The release is synchronised so that every flop on rst_n leaves reset on
  // the same edge; assertion stays asynchronous.
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Step pattern
  // ----------------------------------------------------------------
  // A decade is long on tenths 0, 1, 3, 5, 7 and 9 and short on the
  // others. Odd hundredths take three ticks, and a long decade also
  // takes three on hundredths zero.
  function automatic logic [1:0] step_len(input logic [3:0] hund,
                                          input logic [3:0] tenth);
    logic long_dec;
    long_dec = tenth[0] | (tenth == 4'h0);
    if (hund[0] || (long_dec && (hund == 4'h0))) begin
      step_len = bsw_pkg::LONG_STEP;
    end else begin
      step_len = bsw_pkg::SHORT_STEP;
    end
  endfunction

  function automatic logic [3:0] bcd_inc(input logic [3:0] d);
    if (d == bsw_pkg::DIGIT_MAX) begin
      bcd_inc = bsw_pkg::DIGIT_RST;
    end else begin
      bcd_inc = d + 4'h1;
    end
  endfunction

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  bsw_pkg::bsw_req_s req;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  wire sel_ctrl  = (req.addr == bsw_pkg::CTRL_ADDR);
  wire sel_hund  = (req.addr == bsw_pkg::HUND_ADDR);
  wire sel_tenth = (req.addr == bsw_pkg::TENTH_ADDR);
  wire sel_ien   = (req.addr == bsw_pkg::IEN_ADDR);
  wire sel_pend  = (req.addr == bsw_pkg::PEND_ADDR);

  wire wr_ctrl = req.wr & sel_ctrl;
  wire wr_ien  = req.wr & sel_ien;
  wire wr_pend = req.wr & sel_pend;
  wire clr_w   = wr_ctrl & req.wdata[bsw_pkg::CLEAR_BIT];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic       run;
  logic [3:0] hund;
  logic [3:0] tenth;
  logic [1:0] pre;
  logic [1:0] ien;
  logic [1:0] pend;

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  wire [1:0] cur_len = step_len(hund, tenth);
  wire [1:0] pre_inc = pre + 2'h1;
  wire       cnt_en  = run & tick_256hz_i;
  wire       adv     = cnt_en & (pre_inc == cur_len);
  wire       ovf_lo  = adv & ~clr_w & (hund == bsw_pkg::DIGIT_MAX);
  wire       ovf_hi  = ovf_lo & (tenth == bsw_pkg::DIGIT_MAX);

  logic [1:0] next_pre;
  logic [3:0] next_hund;
  logic [3:0] next_tenth;

  // A clear overrides a tick in the same cycle; if running, the next
  // tick counts from zero at once, otherwise zero is held.
  always_comb begin
    next_pre   = pre;
    next_hund  = hund;
    next_tenth = tenth;
    if (clr_w) begin
      next_pre   = bsw_pkg::PRE_RST;
      next_hund  = bsw_pkg::DIGIT_RST;
      next_tenth = bsw_pkg::DIGIT_RST;
    end else if (adv) begin
      next_pre  = bsw_pkg::PRE_RST;
      next_hund = bcd_inc(hund);
      if (ovf_lo) begin
        next_tenth = bcd_inc(tenth);
      end
    end else if (cnt_en) begin
      next_pre = pre_inc;
    end
  end

  // ----------------------------------------------------------------
  // Control, enables and flags
  // ----------------------------------------------------------------
  wire       next_run = wr_ctrl ? req.wdata[bsw_pkg::RUN_BIT] : run;
  wire [1:0] next_ien = wr_ien ? req.wdata[1:0] : ien;
  wire [1:0] ovf_vec  = {ovf_hi, ovf_lo};
  wire [1:0] clr_vec  = wr_pend ? req.wdata[1:0] : 2'h0;

  // Set beats clear so an overflow in the clearing cycle is kept.
  wire [1:0] next_pend = (pend & ~clr_vec) | ovf_vec;
  wire [1:0] next_irq  = next_pend & next_ien;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped addresses and unused bits read zero.
  logic [3:0] rd_mux;

  always_comb begin
    rd_mux = 4'h0;
    if (sel_ctrl) begin
      rd_mux = {3'h0, run};
    end else if (sel_hund) begin
      rd_mux = hund;
    end else if (sel_tenth) begin
      rd_mux = tenth;
    end else if (sel_ien) begin
      rd_mux = {2'h0, ien};
    end else if (sel_pend) begin
      rd_mux = {2'h0, pend};
    end
  end

  wire [3:0] next_rdata = req.rd ? rd_mux : bsw_pkg::RDATA_RST;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      run   <= 1'b0;
      hund  <= bsw_pkg::DIGIT_RST;
      tenth <= bsw_pkg::DIGIT_RST;
      pre   <= bsw_pkg::PRE_RST;
    end else begin
      run   <= next_run;
      hund  <= next_hund;
      tenth <= next_tenth;
      pre   <= next_pre;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ien  <= bsw_pkg::FLAGS_RST;
      pend <= bsw_pkg::FLAGS_RST;
    end else begin
      ien  <= next_ien;
      pend <= next_pend;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o      <= bsw_pkg::RDATA_RST;
      irq_tenth_o  <= 1'b0;
      irq_second_o <= 1'b0;
    end else begin
      rdata_o      <= next_rdata;
      irq_tenth_o  <= next_irq[bsw_pkg::TENTH_BIT];
      irq_second_o <= next_irq[bsw_pkg::SECOND_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_digit_ro: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    req.wr && (sel_hund || sel_tenth) && !adv && !clr_w
    |=> $stable(hund) && $stable(tenth))
    else $error("Digit write changed a digit.");

  chk_digit_read: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    req.rd && sel_hund |=> rdata_o == $past(hund))
    else $error("Hundredths read returned wrong data.");

  chk_reset_state: assert property (
    @(posedge core_clk_i)
    $rose(rst_n) |-> hund == 4'h0 && tenth == 4'h0 && !run
    && ien == 2'h0 && pend == 2'h0)
    else $error("State not cleared by reset.");

  chk_clear_zero: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    clr_w |=> hund == 4'h0 && tenth == 4'h0 && pre == 2'h0)
    else $error("Clear did not zero the counter.");

  chk_clear_reads: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    req.rd && sel_ctrl |=> rdata_o[1] == 1'b0)
    else $error("Clear bit read as one.");

  chk_run_back: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    req.rd && sel_ctrl |=> rdata_o == {3'h0, $past(run)})
    else $error("Run bit readback wrong.");

  chk_stop_hold: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    !run && !clr_w |=> $stable(hund) && $stable(tenth) && $stable(pre))
    else $error("Stopped counter moved.");

  chk_step_bound: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    pre < cur_len)
    else $error("Prescaler passed the step length.");

  chk_wrap_flag: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    ovf_lo |=> pend[0] && hund == 4'h0)
    else $error("Hundredths wrap did not flag.");

  chk_flag_clear: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    wr_pend && req.wdata[1] && !ovf_hi |=> !pend[1])
    else $error("Second flag not cleared.");

  chk_irq_gate: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    irq_tenth_o == (pend[0] && ien[0]) && irq_second_o == (pend[1] && ien[1]))
    else $error("Interrupt request does not match flag and enable.");

  chk_tenth_wrap: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    ovf_hi |=> pend[1] && tenth == 4'h0)
    else $error("Tenths wrap did not flag.");

  chk_digit_bcd: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    hund <= bsw_pkg::DIGIT_MAX && tenth <= bsw_pkg::DIGIT_MAX)
    else $error("Digit left the decimal range.");

  chk_flag_keep: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    wr_pend && !req.wdata[0] && pend[0] |=> pend[0])
    else $error("Writing zero cleared the tenth second flag.");

  chk_ien_write: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    wr_ien |=> ien == $past(req.wdata[1:0]))
    else $error("Enable write not stored.");

  chk_pre_count: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    cnt_en && !adv && !clr_w |=> pre == $past(pre_inc))
    else $error("Running tick not counted.");

  chk_hund_step: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    adv && !clr_w |=> hund != $past(hund))
    else $error("Hundredths did not advance at step end.");

endmodule

`default_nettype wire

/* File: test/bsw_testbench.sv */
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic        clk;
  logic        rstn;
  logic        tick;
  logic [15:0] addr;
  logic [3:0]  wdata;
  logic        wr;
  logic        rd;
  logic [3:0]  rdata;
  logic        irq_t;
  logic        irq_s;
  logic [3:0]  mh;
  logic [3:0]  mt;
  logic [1:0]  mp;
  logic        mrun;
  int          pre;
  int          errors;
  int          tests_run;

  bsw_stopwatch u_dut (
    .core_clk_i   (clk),
    .rstn_i       (rstn),
    .tick_256hz_i (tick),
    .addr_i       (addr),
    .wdata_i      (wdata),
    .wr_i         (wr),
    .rd_i         (rd),
    .rdata_o      (rdata),
    .irq_tenth_o  (irq_t),
    .irq_second_o (irq_s)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Bus and model helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [15:0] a, input logic [3:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [15:0] a, input logic [3:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask

  // A step is long for odd hundredths and for the first step of a long decade.
  function automatic int stp();
    if (mh[0] || (mh == 4'h0 && (mt == 4'h0 || mt[0]))) return int'(bsw_pkg::LONG_STEP);
    return int'(bsw_pkg::SHORT_STEP);
  endfunction

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      if (mrun) begin
        pre++;
        if (pre == stp()) begin
          pre = 0;
          if (mh == bsw_pkg::DIGIT_MAX) begin
            mh    = 4'h0;
            mp[0] = 1'b1;
            if (mt == bsw_pkg::DIGIT_MAX) begin
              mt    = 4'h0;
              mp[1] = 1'b1;
            end else mt++;
          end else mh++;
        end
      end
    end
  endtask

  // Both digits are read with the counter halted so that no carry can tear them.
  task automatic digits();
    logic was_run;
    was_run = mrun;
    if (was_run) wreg(bsw_pkg::CTRL_ADDR, 4'h0);
    rchk(bsw_pkg::HUND_ADDR, mh);
    rchk(bsw_pkg::TENTH_ADDR, mt);
    if (was_run) wreg(bsw_pkg::CTRL_ADDR, 4'h1);
  endtask

  task automatic ctrl(input logic [3:0] d);
    wreg(bsw_pkg::CTRL_ADDR, d);
    mrun = d[0];
    if (d[1]) begin
      mh  = 4'h0;
      mt  = 4'h0;
      pre = 0;
    end
  endtask

  task automatic do_reset();
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    mh   = 4'h0;
    mt   = 4'h0;
    mp   = 2'h0;
    mrun = 1'b0;
    pre  = 0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    digits();
    rchk(bsw_pkg::CTRL_ADDR, 4'h0);
    rchk(bsw_pkg::IEN_ADDR, 4'h0);
    rchk(bsw_pkg::PEND_ADDR, 4'h0);
    rchk(16'hFF7F, 4'h0);
    chk({2'h0, irq_s, irq_t}, 4'h0);
  endtask

  task automatic t_access();
    wreg(bsw_pkg::HUND_ADDR, 4'h5);
    wreg(bsw_pkg::TENTH_ADDR, 4'h7);
    digits();
    ctrl(4'h1);
    rchk(bsw_pkg::CTRL_ADDR, 4'h1);
    ctrl(4'h0);
    rchk(bsw_pkg::CTRL_ADDR, 4'h0);
  endtask

  // Step and decade lengths are judged against the tick counts themselves.
  task automatic t_count();
    logic [3:0] last_h;
    int         step_n;
    int         dec_n;
    int         n_short;
    int         n_long;
    int         n_bad;
    step_n  = 0;
    dec_n   = 0;
    n_short = 0;
    n_long  = 0;
    n_bad   = 0;
    ctrl(4'h1);
    repeat (256) begin
      last_h = mh;
      ticks(1);
      step_n++;
      dec_n++;
      digits();
      rchk(bsw_pkg::PEND_ADDR, {2'h0, mp});
      chk({2'h0, irq_s, irq_t}, 4'h0);
      if (mh != last_h) begin
        if (step_n != 2 && step_n != 3) n_bad++;
        step_n = 0;
      end
      if (mh == 4'h0 && last_h == bsw_pkg::DIGIT_MAX) begin
        if (dec_n == 25) n_short++;
        else if (dec_n == 26) n_long++;
        else n_bad++;
        dec_n = 0;
      end
    end
    chk({2'h0, mp}, 4'h3);
    chk(4'(n_bad), 4'h0);
    chk(4'(n_short), 4'h4);
    chk(4'(n_long), 4'h6);
  endtask

  task automatic t_hold_clear();
    ticks(5);
    ctrl(4'h0);
    ticks(4);
    digits();
    ctrl(4'h1);
    ticks(1);
    digits();
    ctrl(4'h3);
    ticks(2);
    digits();
    ticks(1);
    digits();
    ctrl(4'h2);
    ticks(4);
    digits();
    rchk(bsw_pkg::CTRL_ADDR, 4'h0);
    ctrl(4'h1);
    ticks(3);
    digits();
    ctrl(4'h1);
    digits();
  endtask

  task automatic t_irq();
    wreg(bsw_pkg::IEN_ADDR, 4'h1);
    rchk(bsw_pkg::IEN_ADDR, 4'h1);
    chk({2'h0, irq_s, irq_t}, 4'h1);
    wreg(bsw_pkg::IEN_ADDR, 4'h3);
    wreg(bsw_pkg::PEND_ADDR, 4'h0);
    rchk(bsw_pkg::PEND_ADDR, 4'h3);
    chk({2'h0, irq_s, irq_t}, 4'h3);
    wreg(bsw_pkg::PEND_ADDR, 4'h1);
    rchk(bsw_pkg::PEND_ADDR, 4'h2);
    chk({2'h0, irq_s, irq_t}, 4'h2);
    wreg(bsw_pkg::PEND_ADDR, 4'h2);
    rchk(bsw_pkg::PEND_ADDR, 4'h0);
    wreg(bsw_pkg::IEN_ADDR, 4'h2);
    rchk(bsw_pkg::IEN_ADDR, 4'h2);
    mp = 2'h0;
  endtask

  // The watchdog stands in for any hang, since the bench has no handshake waits.
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    test_done();
  end

  initial begin
    errors    = 0;
    tests_run = 0;
    rstn      = 1'b0;
    tick      = 1'b0;
    addr      = 16'h0000;
    wdata     = 4'h0;
    wr        = 1'b0;
    rd        = 1'b0;
    do_reset();
    t_reset();
    t_access();
    t_count();
    t_hold_clear();
    t_irq();
    ticks(7);
    wreg(bsw_pkg::IEN_ADDR, 4'h3);
    do_reset();
    t_reset();
    test_done();
  end
endmodule

`default_nettype wire
